// file: bench/kbc_host_if_monitor.sv
// kbc_host_if_monitor.sv : port assertions for kbc_host_if
// assumes: bound to kbc_host_if, single clock domain
`timescale 1ns/100ps
module kbc_chk
(
   input wire       i_sys_clk, i_rst_b, i_host_wr, i_host_rd,
   input wire       i_core_obuf_wr, i_core_ibuf_rd, i_core_p2_wr,
   input wire       i_core_halt, i_ibf_int_en,
   input wire [7:0] i_host_addr, i_core_p2_data,
   input wire [7:0] o_core_status, o_host_rdata,
   input wire       o_kbd_irq_out, o_ibf_int, o_addr_line_gate,
   input wire       o_alu_clk_en,
   input wire [3:0] o_kbm_line_out, o_kbm_line_oe_b
);
   reg [7:0] p2_q;
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_b);
   // last port2 value offered, for the one-cycle line check
   always @(posedge i_sys_clk)
      p2_q <= i_core_p2_data;
   ////////////////////////////////////////
   property p_wr_data;
      i_host_wr && i_host_addr == 8'h60
      |=> o_core_status[1] && !o_core_status[3];
   endproperty
   a_wr_data: assert property (p_wr_data)
      else $error("data write flags wrong");
   property p_wr_cmd;
      i_host_wr && i_host_addr == 8'h64
      |=> o_core_status[1] && o_core_status[3];
   endproperty
   a_wr_cmd: assert property (p_wr_cmd)
      else $error("command write flags wrong");
   property p_stat_rd;
      i_host_rd && i_host_addr == 8'h64
      |=> o_host_rdata == $past(o_core_status);
   endproperty
   a_stat_rd: assert property (p_stat_rd)
      else $error("status read data wrong");
   property p_obuf;
      i_core_obuf_wr |=> o_core_status[0];
   endproperty
   a_obuf: assert property (p_obuf)
      else $error("core write did not set obf");
   property p_ibuf_clr;
      i_core_ibuf_rd && !i_host_wr |=> !o_core_status[1];
   endproperty
   a_ibuf_clr: assert property (p_ibuf_clr)
      else $error("core read did not clear ibf");
   property p_ibf_int;
      o_ibf_int == (i_ibf_int_en && o_core_status[1]);
   endproperty
   a_ibf_int: assert property (p_ibf_int)
      else $error("ibf interrupt wrong");
   // a released line is enable high, so enable is the inverted port bit
   property p_p2_lines;
      i_core_p2_wr |=> o_kbm_line_out == 4'h0 && o_addr_line_gate == p2_q[1]
      && o_kbm_line_oe_b == ~{p2_q[2], p2_q[3], p2_q[7], p2_q[6]};
   endproperty
   a_p2_lines: assert property (p_p2_lines)
      else $error("port2 line mapping wrong");
   property p_rst;
      $rose(i_rst_b) |-> o_core_status == 8'h00 && !o_kbd_irq_out
      && o_kbm_line_oe_b == 4'hf;
   endproperty
   a_rst: assert property (p_rst)
      else $error("reset values wrong");
   property p_halt;
      i_core_halt && !i_host_wr |=> !o_alu_clk_en;
   endproperty
   a_halt: assert property (p_halt)
      else $error("halt did not stop alu clock");
endmodule // kbc_chk
bind kbc_host_if kbc_chk chk_u
(
   .i_sys_clk        (i_sys_clk),
   .i_rst_b          (i_rst_b),
   .i_host_wr        (i_host_wr),
   .i_host_rd        (i_host_rd),
   .i_core_obuf_wr   (i_core_obuf_wr),
   .i_core_ibuf_rd   (i_core_ibuf_rd),
   .i_core_p2_wr     (i_core_p2_wr),
   .i_core_halt      (i_core_halt),
   .i_ibf_int_en     (i_ibf_int_en),
   .i_host_addr      (i_host_addr),
   .i_core_p2_data   (i_core_p2_data),
   .o_core_status    (o_core_status),
   .o_host_rdata     (o_host_rdata),
   .o_kbd_irq_out    (o_kbd_irq_out),
   .o_ibf_int        (o_ibf_int),
   .o_addr_line_gate (o_addr_line_gate),
   .o_alu_clk_en     (o_alu_clk_en),
   .o_kbm_line_out   (o_kbm_line_out),
   .o_kbm_line_oe_b  (o_kbm_line_oe_b)
);

// file: bench/kbc_host_if_test.sv
// kbc_host_if_test.sv : self-checking bench for kbc_host_if
// assumes: kbc_host_model drives the host port, bench drives the core
`timescale 1ns/100ps
module kbc_host_if_test;
   reg        i_sys_clk = 1'b0, i_rst_b = 1'b0;
   reg        i_core_obuf_wr = 1'b0, i_core_ibuf_rd = 1'b0;
   reg        i_core_status_wr = 1'b0, i_core_en_flags = 1'b0;
   reg        i_core_p2_wr = 1'b0, i_core_od_sel = 1'b0;
   reg        i_core_halt = 1'b0, i_core_stop = 1'b0;
   reg        i_timer_ovf = 1'b0, i_ibf_int_en = 1'b0, i_tmr_int_en = 1'b0;
   reg  [7:0] i_core_obuf_data = 8'h00, i_core_status_data = 8'h00;
   reg  [7:0] i_core_p2_data = 8'h00, v;
   reg  [3:0] i_kbm_line_in = 4'h0;
   reg  [2:0] i_core_p1_val = 3'h0;
   wire [7:0] i_host_addr, i_host_wdata, o_host_rdata;
   wire [7:0] o_core_ibuf_data, o_core_status;
   wire       i_host_wr, i_host_rd, o_ibf_int, o_tmr_int;
   wire       o_alu_clk_en, o_osc_en, o_core_restart, o_halt_via_int;
   wire       o_kbd_irq_out, o_aux_irq_out, o_addr_line_gate;
   wire [1:0] o_test_in, o_port1_in;
   wire [3:0] o_kbm_line_out, o_kbm_line_oe_b;
   wire [2:0] o_p1_pad_out, o_p1_pad_oe_b;
   integer    err_total = 0, comparisons = 0, i;
   reg [14:0] rows [0:6];
   always #2.5 i_sys_clk = ~i_sys_clk;
   kbc_host_if dut_u
   (
      .i_sys_clk          (i_sys_clk),
      .i_rst_b            (i_rst_b),
      .i_host_addr        (i_host_addr),
      .i_host_wr          (i_host_wr),
      .i_host_rd          (i_host_rd),
      .i_host_wdata       (i_host_wdata),
      .o_host_rdata       (o_host_rdata),
      .i_core_obuf_wr     (i_core_obuf_wr),
      .i_core_obuf_data   (i_core_obuf_data),
      .i_core_ibuf_rd     (i_core_ibuf_rd),
      .o_core_ibuf_data   (o_core_ibuf_data),
      .i_core_status_wr   (i_core_status_wr),
      .i_core_status_data (i_core_status_data),
      .o_core_status      (o_core_status),
      .i_core_en_flags    (i_core_en_flags),
      .i_core_p2_wr       (i_core_p2_wr),
      .i_core_p2_data     (i_core_p2_data),
      .i_core_od_sel      (i_core_od_sel),
      .i_core_halt        (i_core_halt),
      .i_core_stop        (i_core_stop),
      .i_timer_ovf        (i_timer_ovf),
      .i_ibf_int_en       (i_ibf_int_en),
      .i_tmr_int_en       (i_tmr_int_en),
      .o_ibf_int          (o_ibf_int),
      .o_tmr_int          (o_tmr_int),
      .o_alu_clk_en       (o_alu_clk_en),
      .o_osc_en           (o_osc_en),
      .o_core_restart     (o_core_restart),
      .o_halt_via_int     (o_halt_via_int),
      .o_test_in          (o_test_in),
      .o_port1_in         (o_port1_in),
      .o_kbd_irq_out      (o_kbd_irq_out),
      .o_aux_irq_out      (o_aux_irq_out),
      .o_addr_line_gate   (o_addr_line_gate),
      .i_kbm_line_in      (i_kbm_line_in),
      .o_kbm_line_out     (o_kbm_line_out),
      .o_kbm_line_oe_b    (o_kbm_line_oe_b),
      .o_p1_pad_out       (o_p1_pad_out),
      .o_p1_pad_oe_b      (o_p1_pad_oe_b),
      .i_core_p1_val      (i_core_p1_val)
   );
   kbc_host_model host_u (.i_sys_clk(i_sys_clk), .i_rdata(o_host_rdata),
      .o_addr(i_host_addr), .o_wdata(i_host_wdata), .o_wr(i_host_wr),
      .o_rd(i_host_rd));
   ////////////////////////////////////////
   task ck(input [127:0] n, input [7:0] e, input [7:0] s);
      begin
         comparisons = comparisons + 1;
         if (s !== e)
         begin
            err_total = err_total + 1;
            $display("ERROR %0s exp %h seen %h", n, e, s);
         end
      end
   endtask
   task cy(input integer n);
      repeat (n) @(negedge i_sys_clk);
   endtask
   task p2w(input [7:0] d);
      begin
         {i_core_p2_data, i_core_p2_wr} = {d, 1'b1};
         cy(1);
         i_core_p2_wr = 1'b0;
      end
   endtask
   task obw(input [7:0] d);
      begin
         {i_core_obuf_data, i_core_obuf_wr} = {d, 1'b1};
         cy(1);
         i_core_obuf_wr = 1'b0;
      end
   endtask
   task end_of_test;
      begin
         $display("checks %0d errors %0d", comparisons, err_total);
         if (err_total == 0 && comparisons > 0)
            $display("Run complete: PASS");
         else
            $display("Run complete: FAIL");
         $finish;
      end
   endtask
   // whole run needs about 200 cycles, limit allows 4000
   initial
   begin
      #20000;
      err_total = err_total + 1;
      end_of_test;
   end
   ////////////////////////////////////////
   initial
   begin
      // port2 value, then kbd irq, aux irq, gate, line oe_b 3..0
      // a port bit of one pulls its line low, so enable low
      rows[0] = {8'h00, 7'b000_1111};
      rows[1] = {8'h10, 7'b100_1111};
      rows[2] = {8'h20, 7'b010_1111};
      rows[3] = {8'h02, 7'b001_1111};
      rows[4] = {8'h44, 7'b000_0110};
      rows[5] = {8'h88, 7'b000_1001};
      rows[6] = {8'hff, 7'b111_0000};
      cy(2);
      i_rst_b = 1'b1;
      for (i = 0; i < 7; i = i + 1)
      begin
         p2w(rows[i][14:7]);
         cy(3);
         ck("kbd irq", rows[i][6], o_kbd_irq_out);
         ck("aux irq", rows[i][5], o_aux_irq_out);
         ck("gate", rows[i][4], o_addr_line_gate);
         ck("line oe", rows[i][3:0], o_kbm_line_oe_b);
         ck("line out", 8'h00, o_kbm_line_out);
      end
      $display("rows done");
      i_rst_b = 1'b0;
      cy(2);
      ck("restart", 8'h01, o_core_restart);
      i_rst_b = 1'b1;
      ck("status", 8'h00, o_core_status);
      ck("kbd irq", 8'h00, o_kbd_irq_out);
      ck("line oe", 8'h0f, o_kbm_line_oe_b);
      {i_core_status_data, i_core_status_wr} = {8'hff, 1'b1};
      cy(1);
      ck("user bits", 8'hf4, o_core_status);
      i_core_status_data = 8'h00;
      cy(1);
      i_core_status_wr = 1'b0;
      $display("reset done");
      host_u.wr(8'h64, 8'ha5);
      ck("status", 8'h0a, o_core_status);
      ck("ibuf", 8'ha5, o_core_ibuf_data);
      host_u.rd(8'h64, v);
      ck("status read", 8'h0a, v);
      ck("status", 8'h0a, o_core_status);
      i_core_ibuf_rd = 1'b1;
      cy(1);
      i_core_ibuf_rd = 1'b0;
      ck("status", 8'h08, o_core_status);
      host_u.wr(8'h60, 8'h5a);
      host_u.wr(8'h6c, 8'hc3);
      ck("status", 8'h02, o_core_status);
      ck("ibuf", 8'h5a, o_core_ibuf_data);
      obw(8'h3c);
      ck("status", 8'h03, o_core_status);
      host_u.rd(8'h60, v);
      ck("data read", 8'h3c, v);
      ck("status", 8'h03, o_core_status);
      $display("host done");
      i_core_en_flags = 1'b1;
      cy(1);
      i_core_en_flags = 1'b0;
      i_core_ibuf_rd = 1'b1;
      p2w(8'h30);
      i_core_ibuf_rd = 1'b0;
      cy(3);
      ck("kbd irq", 8'h01, o_kbd_irq_out);
      ck("aux irq", 8'h01, o_aux_irq_out);
      host_u.wr(8'h60, 8'h11);
      cy(3);
      ck("aux irq", 8'h00, o_aux_irq_out);
      host_u.rd(8'h60, v);
      cy(3);
      ck("status", 8'h02, o_core_status);
      ck("kbd irq", 8'h00, o_kbd_irq_out);
      p2w(8'h20);
      obw(8'h77);
      cy(3);
      ck("kbd irq", 8'h00, o_kbd_irq_out);
      $display("flags done");
      i_core_p1_val = 3'h7;
      cy(50);
      ck("pad oe", 8'h00, o_p1_pad_oe_b);
      ck("pad out", 8'h07, o_p1_pad_out);
      cy(60);
      ck("pad oe", 8'h07, o_p1_pad_oe_b);
      {i_core_od_sel, i_core_p1_val} = {1'b1, 3'h0};
      cy(3);
      ck("pad oe", 8'h00, o_p1_pad_oe_b);
      ck("pad out", 8'h00, o_p1_pad_out);
      i_core_p1_val = 3'h7;
      cy(3);
      ck("pad oe", 8'h07, o_p1_pad_oe_b);
      i_kbm_line_in = 4'b0101;
      cy(4);
      ck("test in", 8'h03, o_test_in);
      ck("port1 in", 8'h00, o_port1_in);
      $display("pins done");
      {i_timer_ovf, i_tmr_int_en, i_ibf_int_en} = 3'b111;
      cy(1);
      ck("tmr int", 8'h01, o_tmr_int);
      ck("ibf int", 8'h01, o_ibf_int);
      i_core_halt = 1'b1;
      cy(1);
      i_core_halt = 1'b0;
      ck("alu clk", 8'h00, o_alu_clk_en);
      host_u.wr(8'h64, 8'h22);
      ck("halt int", 8'h01, o_halt_via_int);
      cy(1);
      ck("alu clk", 8'h01, o_alu_clk_en);
      ck("halt int", 8'h00, o_halt_via_int);
      i_core_stop = 1'b1;
      cy(1);
      i_core_stop = 1'b0;
      ck("osc", 8'h00, o_osc_en);
      host_u.wr(8'h60, 8'h33);
      cy(1);
      ck("osc", 8'h01, o_osc_en);
      $display("power done");
      end_of_test;
   end
endmodule // kbc_host_if_test

// file: bench/kbc_host_model.sv
// kbc_host_model.sv : host issuing one-cycle i/o strobes
// assumes: strobes sampled on the rising edge of i_sys_clk
`timescale 1ns/100ps
module kbc_host_model
(
   input  wire       i_sys_clk,
   input  wire [7:0] i_rdata,
   output reg  [7:0] o_addr,
   output reg  [7:0] o_wdata,
   output reg        o_wr,
   output reg        o_rd
);
   initial {o_addr, o_wdata, o_wr, o_rd} = 18'h00000;
   ////////////////////////////////////////
   // idle bus shows inverted values so stale ones cannot match
   task wr(input [7:0] a, input [7:0] d);
      begin
         @(negedge i_sys_clk);
         {o_addr, o_wdata, o_wr} = {a, d, 1'b1};
         @(negedge i_sys_clk);
         {o_addr, o_wdata, o_wr} = {~a, ~d, 1'b0};
      end
   endtask
   task rd(input [7:0] a, output [7:0] d);
      begin
         @(negedge i_sys_clk);
         {o_addr, o_rd} = {a, 1'b1};
         @(negedge i_sys_clk);
         {o_addr, o_rd} = {~a, 1'b0};
         d = i_rdata;
      end
   endtask
endmodule // kbc_host_model

// file: hdl/kbc_host_if.v
// kbc_host_if.v : host side of the embedded keyboard controller core
// assumes: host cycles decoded to one-cycle strobes on i_sys_clk; core
// strobes come from the embedded cpu on the same clock; pins are async
//
// Summary of operation
// RULE1 - host write to data address loads input data, clears cmd flag, sets ibf
// RULE2 - host write to command address loads input data, sets cmd flag and ibf
// RULE3 - host read of command address returns status, no side effects
// RULE4 - with flags enabled, host data read clears obf and keyboard irq
// RULE5 - core write of data bus buffer loads output data, sets obf
// RULE6 - every host write copies host address bit two into status bit 3; code copies it only on writes to 8'h60 and 8'h64
// RULE7 - flags enabled and port2 bit4 high: keyboard irq follows obf
// RULE8 - flags enabled and port2 bit4 low: keyboard irq held low
// RULE9 - flags disabled: keyboard irq follows port2 bit4 directly
// RULE10 - after reset the keyboard irq output is zero
// RULE11 - flags enabled and port2 bit5 high: aux irq is inverse of ibf
// RULE12 - flags disabled: aux irq follows port2 bit5 directly
// RULE13 - port2 bit1 serves as address line gate or user output
// RULE14 - push-pull port one drives high about six clocks then releases; code drives high for 100 clocks (500 ns at 5 ns)
// RULE15 - open-drain port pins drive low for zero, tri-state for one
// RULE16 - port pins cannot be made inputs or inverted
// RULE17 - keyboard and mouse lines are inverted port2 bits, read back on inputs
// RULE18 - halt stops alu clock until reset or host input write
// RULE19 - leaving powerdown by reset restarts at program address zero
// RULE20 - stop disables oscillator until reset or host input write
// RULE21 - core has only ibf and timer overflow interrupt sources
// RULE22 - status resets to zero, host read-only, core writes bits 7-4, 2
// RULE23 - core read of input buffer clears ibf and its interrupt
// RULE24 - flag handling enable stays set until next hardware reset
`timescale 1ns/100ps
`include "kbc_map.vh"

module kbc_host_if
(
   // clock and reset
   input  wire       i_sys_clk,
   input  wire       i_rst_b,
   // host port
   input  wire [7:0] i_host_addr,
   input  wire       i_host_wr,
   input  wire       i_host_rd,
   input  wire [7:0] i_host_wdata,
   output reg  [7:0] o_host_rdata,
   // embedded core side
   input  wire       i_core_obuf_wr,
   input  wire [7:0] i_core_obuf_data,
   input  wire       i_core_ibuf_rd,
   output reg  [7:0] o_core_ibuf_data,
   input  wire       i_core_status_wr,
   input  wire [7:0] i_core_status_data,
   output wire [7:0] o_core_status,
   input  wire       i_core_en_flags,
   input  wire       i_core_p2_wr,
   input  wire [7:0] i_core_p2_data,
   input  wire       i_core_od_sel,
   input  wire       i_core_halt,
   input  wire       i_core_stop,
   input  wire       i_timer_ovf,
   input  wire       i_ibf_int_en,
   input  wire       i_tmr_int_en,
   // core control
   output wire       o_ibf_int,
   output wire       o_tmr_int,
   output wire       o_alu_clk_en,
   output wire       o_osc_en,
   output wire       o_core_restart,
   output wire       o_halt_via_int,
   output wire [1:0] o_test_in,
   output wire [1:0] o_port1_in,
   // system outputs
   output reg        o_kbd_irq_out,
   output reg        o_aux_irq_out,
   output wire       o_addr_line_gate,
   // keyboard and mouse open-drain lines
   input  wire [3:0] i_kbm_line_in,
   output wire [3:0] o_kbm_line_out,
   output wire [3:0] o_kbm_line_oe_b,
   // port pins for port1 bits 7,6,2
   output wire [2:0] o_p1_pad_out,
   output wire [2:0] o_p1_pad_oe_b,
   input  wire [2:0] i_core_p1_val
);

   ////////////////////////////////////////////////////////////////////
   // state

   reg [7:0] status_q;
   reg [7:0] obuf_q;
   reg [7:0] p2_q;
   reg       en_flags_q;
   reg [2:0] pwr_q;
   reg [2:0] pwr_d;
   reg       restart_q;
   reg       halt_int_q;
   reg [3:0] line_s1_q;
   reg [3:0] line_s2_q;

   wire host_wr_data = i_host_wr && (i_host_addr == `KBC_ADDR_DATA);
   wire host_wr_cmd  = i_host_wr && (i_host_addr == `KBC_ADDR_CMD);
   wire host_wr_in   = host_wr_data || host_wr_cmd;
   wire host_rd_data = i_host_rd && (i_host_addr == `KBC_ADDR_DATA);
   wire host_rd_stat = i_host_rd && (i_host_addr == `KBC_ADDR_CMD);

   assign o_core_status = status_q;

   ////////////////////////////////////////////////////////////////////
   // status register and data buffers

   always @(posedge i_sys_clk)
   begin
      if (!i_rst_b)
      begin
         status_q         <= `KBC_ST_RESET; // see RULE22
         obuf_q           <= 8'h00;
         o_core_ibuf_data <= 8'h00;
         en_flags_q       <= 1'b0;
      end
      else
      begin
         if (i_core_en_flags)
            en_flags_q <= 1'b1; // see RULE24
         if (i_core_status_wr)
            status_q <= (status_q & ~`KBC_ST_USER_MASK)
                      | (i_core_status_data & `KBC_ST_USER_MASK); // see RULE22
         // core read first so a same-cycle host write still sets ibf
         if (i_core_ibuf_rd)
            status_q[`KBC_ST_IBF] <= 1'b0; // see RULE23
         if (host_wr_in)
         begin
            o_core_ibuf_data      <= i_host_wdata; // see RULE1
            status_q[`KBC_ST_IBF] <= 1'b1; // see RULE2
            status_q[`KBC_ST_CD]  <= i_host_addr[`KBC_ADDR_SEL_BIT]; // see RULE6
         end
         if (host_rd_data && en_flags_q)
            status_q[`KBC_ST_OBF] <= 1'b0; // see RULE4
         if (i_core_obuf_wr)
         begin
            obuf_q                <= i_core_obuf_data;
            status_q[`KBC_ST_OBF] <= 1'b1; // see RULE5
         end
      end
   end

   // host read data; status read has no side effects
   always @(posedge i_sys_clk)
   begin
      if (!i_rst_b)
         o_host_rdata <= 8'h00;
      else if (host_rd_stat)
         o_host_rdata <= status_q; // see RULE3
      else if (host_rd_data)
         o_host_rdata <= obuf_q;
   end

   ////////////////////////////////////////////////////////////////////
   // port 2 and interrupt pins

   always @(posedge i_sys_clk)
   begin
      if (!i_rst_b)
         p2_q <= 8'h00;
      else if (i_core_p2_wr)
         p2_q <= i_core_p2_data;
   end

   always @(posedge i_sys_clk)
   begin
      if (!i_rst_b)
      begin
         o_kbd_irq_out <= 1'b0; // see RULE10
         o_aux_irq_out <= 1'b0;
      end
      else if (en_flags_q)
      begin
         // irq takes flag value a cycle after it settles
         o_kbd_irq_out <= p2_q[4] & status_q[`KBC_ST_OBF]; // see RULE7 RULE8
         o_aux_irq_out <= p2_q[5] ? ~status_q[`KBC_ST_IBF]
                                  : p2_q[5]; // see RULE11
      end
      else
      begin
         o_kbd_irq_out <= p2_q[4]; // see RULE9
         o_aux_irq_out <= p2_q[5]; // see RULE12
      end
   end
   // with flags on and bit4 low the and above holds irq low, see RULE8
   // with flags on, aux irq with bit5 high is inverse ibf, see RULE11

   // only a plain output; no input or inversion option exists
   assign o_addr_line_gate = p2_q[1]; // see RULE13

   ////////////////////////////////////////////////////////////////////
   // keyboard / mouse lines: keyboard_clock_line, keyboard_data_line, mclk, mouse_data_line = ~p2 6,7,3,2

   wire [3:0] line_drv = ~{p2_q[2], p2_q[3], p2_q[7], p2_q[6]};
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1)
      begin : g_line
         // open drain: enable low pulls the line low
         assign o_kbm_line_out[gi]  = 1'b0;
         assign o_kbm_line_oe_b[gi] = line_drv[gi]; // see RULE17
      end
   endgenerate

   always @(posedge i_sys_clk)
   begin
      if (!i_rst_b)
      begin
         line_s1_q <= 4'h0;
         line_s2_q <= 4'h0;
      end
      else
      begin
         line_s1_q <= i_kbm_line_in;
         line_s2_q <= line_s1_q;
      end
   end
   // read-back: core_test_in_zero=keyboard_clock_line, p10=keyboard_data_line, core_test_in_one=mclk, p11=mouse_data_line
   assign o_test_in  = {line_s2_q[2], line_s2_q[0]}; // see RULE17
   assign o_port1_in = {line_s2_q[3], line_s2_q[1]};

   ////////////////////////////////////////////////////////////////////
   // port1 output pins, fixed as outputs, never inverted

   generate
      for (gi = 0; gi < 3; gi = gi + 1)
      begin : g_p1
         kbc_port_pin u_pin
         (
            .i_sys_clk    (i_sys_clk),
            .i_rst_b      (i_rst_b),
            .i_val        (i_core_p1_val[gi]), // see RULE16
            .i_open_drain (i_core_od_sel),
            .o_pad_out    (o_p1_pad_out[gi]),
            .o_pad_oe_b   (o_p1_pad_oe_b[gi])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////
   // core interrupts: only ibf and timer overflow

   assign o_ibf_int = i_ibf_int_en & status_q[`KBC_ST_IBF]; // see RULE21
   assign o_tmr_int = i_tmr_int_en & i_timer_ovf; // see RULE21

   ////////////////////////////////////////////////////////////////////
   // power states

   localparam [2:0] PWR_RUN  = `KBC_PWR_RUN;
   localparam [2:0] PWR_HALT = `KBC_PWR_HALT;
   localparam [2:0] PWR_STOP = `KBC_PWR_STOP;

   always @*
   begin
      pwr_d = pwr_q;
      case (pwr_q)
         PWR_RUN:
            if (i_core_stop)
               pwr_d = PWR_STOP; // see RULE20
            else if (i_core_halt)
               pwr_d = PWR_HALT; // see RULE18
         PWR_HALT:
            if (host_wr_in)
               pwr_d = PWR_RUN; // see RULE18
         PWR_STOP:
            if (host_wr_in)
               pwr_d = PWR_RUN; // see RULE20
         default:
            pwr_d = PWR_RUN;
      endcase
   end

   always @(posedge i_sys_clk)
   begin
      if (!i_rst_b)
      begin
         pwr_q      <= PWR_RUN;
         restart_q  <= 1'b1; // see RULE19
         halt_int_q <= 1'b0;
      end
      else
      begin
         pwr_q      <= pwr_d;
         restart_q  <= 1'b0;
         // resume via ibf call only if that interrupt is enabled
         halt_int_q <= (pwr_q != PWR_RUN) && host_wr_in
                       && i_ibf_int_en; // see RULE18
      end
   end

   // timer and interrupts keep running in halt; oscillator off in stop
   assign o_alu_clk_en   = (pwr_q == PWR_RUN);
   assign o_osc_en       = (pwr_q != PWR_STOP); // see RULE20
   assign o_core_restart = restart_q; // see RULE19
   assign o_halt_via_int = halt_int_q;

endmodule // kbc_host_if

// file: hdl/kbc_map.vh
// kbc_map.vh : address map, status field positions, reset values, timing
// assumes: included by the host interface design files of the kbc block
`ifndef KBC_MAP_VH
`define KBC_MAP_VH

// host i/o addresses
`define KBC_ADDR_DATA       8'h60
`define KBC_ADDR_CMD        8'h64
`define KBC_ADDR_SEL_BIT    2

// status register fields
`define KBC_ST_OBF          0
`define KBC_ST_IBF          1
`define KBC_ST_CD           3
`define KBC_ST_RESET        8'h00
`define KBC_ST_USER_MASK    8'hf4

// drive-high time for push-pull port pins
`define KBC_PULL_NS         500
`define KBC_CLK_NS          5
`define KBC_PULL_CYC        ((`KBC_PULL_NS + `KBC_CLK_NS - 1) / `KBC_CLK_NS)
`define KBC_PULL_W          7

// core power states
`define KBC_PWR_RUN         3'b001
`define KBC_PWR_HALT        3'b010
`define KBC_PWR_STOP        3'b100

`endif

// file: hdl/kbc_port_pin.v
// kbc_port_pin.v : one port output pin, push-pull pulse or open drain
// assumes: external pull-up on the pad; i_val from logic on i_sys_clk
`timescale 1ns/100ps
`include "kbc_map.vh"

module kbc_port_pin
(
   // clock and reset
   input  wire i_sys_clk,
   input  wire i_rst_b,
   // control
   input  wire i_val,
   input  wire i_open_drain,
   // pad
   output reg  o_pad_out,
   output reg  o_pad_oe_b
);

   reg                    val_q;
   reg [`KBC_PULL_W-1:0]  cnt_q;
   reg [`KBC_PULL_W-1:0]  cnt_d;

   // count kept wide here and cut on purpose where it loads the counter
   localparam [31:0]      PULL_CYC_W = `KBC_PULL_CYC;

   always @*
   begin
      cnt_d = cnt_q;
      if (i_val && !val_q)
         cnt_d = PULL_CYC_W[`KBC_PULL_W-1:0];
      else if (!i_val)
         cnt_d = {`KBC_PULL_W{1'b0}};
      else if (cnt_q != {`KBC_PULL_W{1'b0}})
         cnt_d = cnt_q - 1'b1;
   end

   always @(posedge i_sys_clk)
   begin
      if (!i_rst_b)
      begin
         val_q      <= 1'b0;
         cnt_q      <= {`KBC_PULL_W{1'b0}};
         o_pad_out  <= 1'b0;
         o_pad_oe_b <= 1'b0;
      end
      else
      begin
         val_q <= i_val;
         cnt_q <= cnt_d;
         if (!i_val)
         begin
            o_pad_out  <= 1'b0;
            o_pad_oe_b <= 1'b0;
         end
         else if (i_open_drain)
         begin
            // no active high drive so the pin can be shared
            o_pad_out  <= 1'b0;
            o_pad_oe_b <= 1'b1; // see RULE15
         end
         else
         begin
            // brief push then let the pull-up hold the level
            o_pad_out  <= 1'b1;
            o_pad_oe_b <= (cnt_d == {`KBC_PULL_W{1'b0}}); // see RULE14
         end
      end
   end

endmodule // kbc_port_pin
